// ---- rtl/lds_defs.svh ----
`ifndef LDS_DEFS_SVH
`define LDS_DEFS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define LDS_A_RSVD 6'h00
`define LDS_A_CTRL1 6'h01
`define LDS_A_CTRL2 6'h02
`define LDS_A_CTRL3 6'h03
`define LDS_A_STAT1 6'h04
`define LDS_A_STAT2 6'h05
`define LDS_A_TRIM 6'h3E
`define LDS_A_GCFG 6'h3F
`define LDS_A_ID 6'h00
`define LDS_A_VER 6'h01
`define LDS_A_PC_LO 6'h02
`define LDS_A_PC_HI 6'h03
`define LDS_A_FRAME 6'h3E
// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define LDS_CTRL1_RST 16'h000E
`define LDS_CTRL2_RST 16'h5E1F
`define LDS_CTRL3_RST 16'h0800
`define LDS_CTRL1_MASK 16'h003F
`define LDS_CTRL2_MASK 16'hFFFF
`define LDS_CTRL3_MASK 16'h1FFF
`define LDS_TRIM_VAL 16'h0000
// ----------------------------------------
// Status layout
// ----------------------------------------
`define LDS_STAT1_LATCH 16'h03FF
`define LDS_STAT1_LIVE 16'h1C00
// ----------------------------------------
// Frame and timing
// ----------------------------------------
`define LDS_FRAME_BITS 5'd24
`define LDS_CMD_LAST 5'd7
`define LDS_CLK_NS 40
`define LDS_OTA_STEP_NS 3300
`define LDS_DRV_STEP_NS 1670
`define LDS_OTA_STEP_CYC ((`LDS_OTA_STEP_NS + `LDS_CLK_NS - 1) / `LDS_CLK_NS)
`define LDS_DRV_STEP_CYC ((`LDS_DRV_STEP_NS + `LDS_CLK_NS - 1) / `LDS_CLK_NS)
`define LDS_WD_SHORT_MS 100
`define LDS_WD_LONG_MS 200
`define LDS_WD_SHORT_CYC (`LDS_WD_SHORT_MS * 1000000 / `LDS_CLK_NS)
`define LDS_WD_LONG_CYC (`LDS_WD_LONG_MS * 1000000 / `LDS_CLK_NS)
`endif

// ---- rtl/lds_pkg.sv ----
`default_nettype none
package lds_pkg;
  typedef enum logic [1:0] {
    LDS_OP_WRITE = 2'h0,
    LDS_OP_READ = 2'h1,
    LDS_OP_RDCLR = 2'h2,
    LDS_OP_INFO = 2'h3
  } lds_op_t;
  typedef enum logic [1:0] {
    LDS_IDLE = 2'h0,
    LDS_CMD = 2'h1,
    LDS_DATA = 2'h3
  } lds_phase_t;
endpackage : lds_pkg
`default_nettype wire

// ---- rtl/lds_port.sv ----
// Operation
// - Write frame stores 16 data bits, sampled on serial clock rise, MSB first.
// - First reply bit appears at select fall, later bits on clock fall.
// - Write reply is status byte then register value before the write.
// - Read reply is status byte then register value; register unchanged.
// - Read of an unused address returns zero data.
// - Status registers are frozen while a frame is running.
// - Read-and-clear returns a status register then clears its latched bits.
// - Read-and-clear at configuration address clears the latched bits of status register one, returns configuration.
// - Read-and-clear and info commands ignore the data bits.
// - Info command reads a fixed read-only identity area.
// - Two-bit field routes one source to monitor output; enable bit drives it.
// - Thermistor foldback follows its bit, except limp mode uses internal monitoring.
// - Watchdog period bit picks 100 ms or 200 ms; resets to one.
// - Dither enable bit; deviation code 0..6 gives 0..30 percent.
// - Two-bit modulation code picks 1.95, 3.9, 7.8 or 15.6 kHz.
// - LED current code in bits 9..5, full scale at 31.
// - Input current limit code in bits 4..0, full scale at 31.
// - Software fallback bit enters limp home without watchdog supervision.
// - Amplifier connects code times 3.3 us after dimming input rises.
// - Converter activates code times 1.67 us after dimming input rises.
// - Dimming switch turns off code times 1.67 us after dimming input falls.
// - Frame is 24 bits: opcode, six-bit address, sixteen data bits.
// - Wrong clock count flags communication error; next valid frame clears it.
// - Select high: deselected, serial output in high impedance.
`include "lds_defs.svh"
`default_nettype none
module lds_port #(
  parameter int WD_SHORT_CYC = `LDS_WD_SHORT_CYC,
  parameter int WD_LONG_CYC = `LDS_WD_LONG_CYC,
  parameter int DLY_W = 11
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic dim_logic_in,
  input wire logic [3:0] monitor_src,
  input wire logic [15:0] fault_src,
  input wire logic [15:0] state_src,
  output logic monitor_out,
  output logic monitor_oe,
  output logic ntc_foldback_en,
  output logic internal_temp_mon,
  output logic fallback_active,
  output logic watchdog_timeout_select,
  output logic [2:0] watchdog_level,
  output logic dither_en,
  output logic [4:0] deviation_pct,
  output logic [1:0] mod_rate_code,
  output logic [4:0] led_current_code,
  output logic [4:0] input_limit_code,
  output logic amp_connect,
  output logic converter_on,
  output logic dimming_switch
);
  import lds_pkg::*;

  // Arbitrary identity values
  localparam logic [15:0] INFO_IDENTITY_HEADER = 16'hA5A0;
  localparam logic [15:0] ID_VERSION = 16'h0001;
  localparam logic [15:0] ID_PROD_LO = 16'h1234;
  localparam logic [15:0] ID_PROD_HI = 16'h5678;
  localparam logic [15:0] ID_FRAME = 16'h9ABC;
  localparam logic [DLY_W-1:0] OTA_STEP = DLY_W'(`LDS_OTA_STEP_CYC);
  localparam logic [DLY_W-1:0] DRV_STEP = DLY_W'(`LDS_DRV_STEP_CYC);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] cs_s;
  logic [2:0] sck_s;
  logic [1:0] sdi_s;
  logic [2:0] dim_s;
  logic [3:0] mon_s1;
  logic [3:0] mon_s2;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_s <= 3'h7;
      sck_s <= 3'h0;
      sdi_s <= 2'h0;
      dim_s <= 3'h0;
      mon_s1 <= 4'h0;
      mon_s2 <= 4'h0;
    end else begin
      cs_s <= {cs_s[1:0], chip_select_n};
      sck_s <= {sck_s[1:0], sck};
      sdi_s <= {sdi_s[0], sdi};
      dim_s <= {dim_s[1:0], dim_logic_in};
      mon_s1 <= monitor_src;
      mon_s2 <= mon_s1;
    end
  end

  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign cs_low = ~cs_s[1];
  assign cs_fall = cs_s[2] & ~cs_s[1];
  assign cs_rise = ~cs_s[2] & cs_s[1];
  assign sck_rise = cs_low & ~sck_s[2] & sck_s[1];
  assign sck_fall = cs_low & sck_s[2] & ~sck_s[1];

  // ----------------------------------------
  // Frame receive
  // ----------------------------------------
  lds_phase_t ph_r;
  logic [4:0] bit_cnt_r;
  logic [23:0] rx_r;
  logic [7:0] cmd_r;
  logic [7:0] cmd_now;
  logic frame_ok;
  lds_op_t op;
  logic [5:0] addr;

  assign cmd_now = {rx_r[6:0], sdi_s[1]};
  assign frame_ok = cs_rise && (bit_cnt_r == `LDS_FRAME_BITS);
  assign op = lds_op_t'(cmd_r[7:6]);
  assign addr = cmd_r[5:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_r <= LDS_IDLE;
      bit_cnt_r <= 5'h0;
      rx_r <= 24'h0;
      cmd_r <= 8'h0;
    end else if (cs_fall) begin
      ph_r <= LDS_CMD;
      bit_cnt_r <= 5'h0;
    end else if (!cs_low) begin
      ph_r <= LDS_IDLE;
    end else if (sck_rise) begin
      rx_r <= {rx_r[22:0], sdi_s[1]};
      if (bit_cnt_r != 5'h1F) begin
        bit_cnt_r <= bit_cnt_r + 5'h1;
      end
      if (ph_r == LDS_CMD && bit_cnt_r == `LDS_CMD_LAST) begin
        cmd_r <= cmd_now;
        ph_r <= LDS_DATA;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [15:0] c1_r;
  logic [15:0] c2_r;
  logic [15:0] c3_r;
  logic [15:0] wdata;
  logic do_write;
  logic wd_refresh;

  assign wdata = rx_r[15:0];
  assign do_write = frame_ok && op == LDS_OP_WRITE;
  assign wd_refresh = do_write && (addr == `LDS_A_CTRL1 || addr == `LDS_A_GCFG)
    && (wdata[0] != c1_r[0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c1_r <= `LDS_CTRL1_RST;
      c2_r <= `LDS_CTRL2_RST;
      c3_r <= `LDS_CTRL3_RST;
    end else if (do_write) begin
      case (addr)
        `LDS_A_CTRL1: c1_r <= wdata & `LDS_CTRL1_MASK;
        `LDS_A_CTRL2: c2_r <= wdata & `LDS_CTRL2_MASK;
        `LDS_A_CTRL3: c3_r <= wdata & `LDS_CTRL3_MASK;
        `LDS_A_GCFG: c1_r[0] <= wdata[0];
        default: c1_r <= c1_r;
      endcase
    end
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  logic [23:0] wd_cnt_r;
  logic [23:0] wd_lim;
  logic [23:0] wd_q;
  logic [23:0] wd_q3;
  logic wd_expired_r;
  logic wd_fire;
  logic sw_limp;
  logic limp_any;
  logic [2:0] wd_stat;

  assign sw_limp = c3_r[12];
  assign limp_any = sw_limp | wd_expired_r;
  assign wd_lim = c1_r[1] ? 24'(WD_LONG_CYC) : 24'(WD_SHORT_CYC);
  assign wd_q = {2'h0, wd_lim[23:2]};
  assign wd_q3 = wd_q + {wd_q[22:0], 1'b0};
  assign wd_fire = !sw_limp && !wd_refresh && (wd_cnt_r == wd_lim - 24'h1);
  assign wd_stat = (wd_cnt_r >= wd_q3) ? 3'h7 :
                   (wd_cnt_r >= {wd_q[22:0], 1'b0}) ? 3'h3 :
                   (wd_cnt_r >= wd_q) ? 3'h1 : 3'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_cnt_r <= 24'h0;
      wd_expired_r <= 1'b0;
    end else if (sw_limp || wd_refresh) begin
      wd_cnt_r <= 24'h0;
      wd_expired_r <= 1'b0;
    end else if (wd_fire) begin
      wd_cnt_r <= 24'h0;
      wd_expired_r <= 1'b1;
    end else begin
      wd_cnt_r <= wd_cnt_r + 24'h1;
    end
  end

  // ----------------------------------------
  // Status registers
  // ----------------------------------------
  logic [15:0] lat_r;
  logic [15:0] snap1_r;
  logic [15:0] snap2_r;
  logic [15:0] live1;
  logic [15:0] live2;
  logic [15:0] stat_set;
  logic [15:0] stat_clr;
  logic comm_err_r;
  logic por_r;
  logic [7:0] gsb;

  assign stat_set = (fault_src & `LDS_STAT1_LATCH) | {15'h0, wd_fire};
  assign live1 = lat_r | (fault_src & `LDS_STAT1_LIVE);
  assign live2 = {7'h0, state_src[8:4], sw_limp, wd_stat};
  assign stat_clr = (frame_ok && op == LDS_OP_RDCLR
    && (addr == `LDS_A_STAT1 || addr == `LDS_A_GCFG)) ? snap1_r : 16'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_r <= 16'h0;
    end else begin
      lat_r <= (lat_r & ~stat_clr) | stat_set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap1_r <= 16'h0;
      snap2_r <= 16'h0;
    end else if (!cs_low) begin
      snap1_r <= live1;
      snap2_r <= live2;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comm_err_r <= 1'b0;
      por_r <= 1'b1;
    end else if (frame_ok) begin
      comm_err_r <= 1'b0;
      por_r <= 1'b0;
    end else if (cs_rise) begin
      comm_err_r <= 1'b1;
    end
  end

  always_comb begin
    gsb[6] = comm_err_r;
    gsb[5] = ~(por_r | comm_err_r);
    gsb[4] = snap1_r[8];
    gsb[3] = snap1_r[9];
    gsb[2] = snap1_r[7] | snap1_r[11];
    gsb[1] = |snap1_r[6:2];
    gsb[0] = snap2_r[3] | snap1_r[1] | snap1_r[0] | wd_expired_r;
    gsb[7] = (|gsb[6:0]) & ~gsb[5] | (|gsb[4:0]) | snap1_r[10] | snap1_r[12];
  end

  // ----------------------------------------
  // Read data select
  // ----------------------------------------
  logic [15:0] rd_data;
  always_comb begin
    rd_data = 16'h0;
    if (cmd_now[7:6] == LDS_OP_INFO) begin
      case (cmd_now[5:0])
        `LDS_A_ID: rd_data = INFO_IDENTITY_HEADER;
        `LDS_A_VER: rd_data = ID_VERSION;
        `LDS_A_PC_LO: rd_data = ID_PROD_LO;
        `LDS_A_PC_HI: rd_data = ID_PROD_HI;
        `LDS_A_FRAME: rd_data = ID_FRAME;
        default: rd_data = 16'h0;
      endcase
    end else begin
      case (cmd_now[5:0])
        `LDS_A_CTRL1: rd_data = c1_r;
        `LDS_A_CTRL2: rd_data = c2_r;
        `LDS_A_CTRL3: rd_data = c3_r;
        `LDS_A_STAT1: rd_data = snap1_r;
        `LDS_A_STAT2: rd_data = snap2_r;
        `LDS_A_TRIM: rd_data = `LDS_TRIM_VAL;
        `LDS_A_GCFG: rd_data = {15'h0, c1_r[0]};
        default: rd_data = 16'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  logic [22:0] tx_r;
  logic sdo_r;
  logic sdo_oe_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_r <= 23'h0;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else if (cs_fall) begin
      sdo_oe_r <= 1'b1;
      sdo_r <= gsb[7];
      tx_r <= {gsb[6:0], 16'h0};
    end else if (!cs_low) begin
      sdo_oe_r <= 1'b0;
    end else if (sck_fall) begin
      sdo_r <= tx_r[22];
      tx_r <= {tx_r[21:0], 1'b0};
    end else if (sck_rise && ph_r == LDS_CMD && bit_cnt_r == `LDS_CMD_LAST) begin
      tx_r[22:7] <= rd_data;
    end
  end

  assign sdo_o = sdo_r;
  assign sdo_oe = sdo_oe_r;

  // ----------------------------------------
  // Analog control outputs
  // ----------------------------------------
  logic mon_out_r;
  logic mon_oe_r;
  logic ntc_r;
  logic int_mon_r;
  logic limp_r;
  logic [2:0] wd_lvl_r;
  logic [4:0] dev_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mon_out_r <= 1'b0;
      mon_oe_r <= 1'b0;
      ntc_r <= 1'b0;
      int_mon_r <= 1'b0;
      limp_r <= 1'b0;
      wd_lvl_r <= 3'h0;
      dev_r <= 5'h0;
    end else begin
      mon_out_r <= mon_s2[c1_r[5:4]];
      mon_oe_r <= c1_r[3];
      ntc_r <= c1_r[2] & ~limp_any;
      int_mon_r <= limp_any;
      limp_r <= limp_any;
      wd_lvl_r <= wd_stat;
      dev_r <= (c2_r[15:13] > 3'h6) ? 5'd30 : {c2_r[15:13], 2'h0} + {2'h0, c2_r[15:13]};
    end
  end

  assign monitor_out = mon_out_r;
  assign monitor_oe = mon_oe_r;
  assign ntc_foldback_en = ntc_r;
  assign internal_temp_mon = int_mon_r;
  assign fallback_active = limp_r;
  assign watchdog_level = wd_lvl_r;
  assign watchdog_timeout_select = c1_r[1];
  assign deviation_pct = dev_r;
  assign dither_en = c2_r[10];
  assign mod_rate_code = c2_r[12:11];
  assign led_current_code = c2_r[9:5];
  assign input_limit_code = c2_r[4:0];

  // ----------------------------------------
  // Dimming edge delays
  // ----------------------------------------
  logic [2:0] dly_out_r;
  logic dim_edge;
  assign dim_edge = dim_s[2] ^ dim_s[1];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_dly
      localparam logic IMM = (gi == 2);
      localparam logic [DLY_W-1:0] STEP = (gi == 0) ? OTA_STEP : DRV_STEP;
      logic [DLY_W-1:0] cnt_r;
      logic [DLY_W-1:0] tgt;
      logic [3:0] code;
      assign code = c3_r[11 - 4 * gi -: 4];
      assign tgt = DLY_W'(code * STEP);
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_r <= '0;
          dly_out_r[gi] <= 1'b0;
        end else if (dim_s[1] == IMM) begin
          cnt_r <= '0;
          dly_out_r[gi] <= IMM;
        end else if (dim_edge) begin
          cnt_r <= tgt;
          if (tgt == '0) begin
            dly_out_r[gi] <= ~IMM;
          end
        end else if (cnt_r == DLY_W'(1)) begin
          cnt_r <= '0;
          dly_out_r[gi] <= ~IMM;
        end else if (cnt_r != '0) begin
          cnt_r <= cnt_r - DLY_W'(1);
        end
      end
    end
  endgenerate

  assign amp_connect = dly_out_r[0];
  assign converter_on = dly_out_r[1];
  assign dimming_switch = dly_out_r[2];
endmodule : lds_port
`default_nettype wire

// ---- test/lds_port_chk_sva.sv ----
`default_nettype none
module lds_port_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic sck,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic dim_logic_in,
  input wire logic monitor_oe,
  input wire logic ntc_foldback_en,
  input wire logic internal_temp_mon,
  input wire logic fallback_active,
  input wire logic watchdog_timeout_select,
  input wire logic [2:0] watchdog_level,
  input wire logic dither_en,
  input wire logic [4:0] deviation_pct,
  input wire logic [1:0] mod_rate_code,
  input wire logic [4:0] led_current_code,
  input wire logic [4:0] input_limit_code,
  input wire logic amp_connect,
  input wire logic converter_on,
  input wire logic dimming_switch
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_idle;
    chip_select_n [*5];
  endsequence
  sequence s_dim_up;
    $rose(dim_logic_in);
  endsequence
  sequence s_dim_dn;
    $fell(dim_logic_in);
  endsequence
  property p_idle_hiz;
    s_idle |-> !sdo_oe;
  endproperty
  property p_oe_on;
    $fell(chip_select_n) |-> ##[1:4] sdo_oe;
  endproperty
  property p_sdo_hold;
    (sck && !chip_select_n) [*2] |-> $stable(sdo_o);
  endproperty
  property p_reset_val;
    $fell(rst) |-> ##2 (watchdog_timeout_select && monitor_oe && ntc_foldback_en && dither_en
      && deviation_pct == 5'h0A && mod_rate_code == 2'h3 && led_current_code == 5'h10
      && input_limit_code == 5'h1F && !dimming_switch);
  endproperty
  property p_wd_lvl;
    watchdog_level inside {3'h0, 3'h1, 3'h3, 3'h7};
  endproperty
  property p_limp;
    fallback_active |-> internal_temp_mon && !ntc_foldback_en;
  endproperty
  property p_dev;
    deviation_pct inside {5'h00, 5'h05, 5'h0A, 5'h0F, 5'h14, 5'h19, 5'h1E};
  endproperty
  property p_dim_up;
    s_dim_up |-> ##[1:6] dimming_switch;
  endproperty
  property p_dim_dn;
    s_dim_dn |-> ##[1:6] (!amp_connect && !converter_on);
  endproperty
  property p_amp_cause;
    $rose(amp_connect) |-> dim_logic_in;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("sdo driven while deselected");
  a_oe_on: assert property (p_oe_on) else $error("sdo not driven after select");
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved with clock high");
  a_reset_val: assert property (p_reset_val) else $error("bad reset outputs");
  a_limp: assert property (p_limp) else $error("limp without internal monitor");
  a_dev: assert property (p_dev) else $error("deviation out of range");
  a_dim_up: assert property (p_dim_up) else $error("switch not on at rise");
  a_dim_dn: assert property (p_dim_dn) else $error("outputs not off at fall");
  a_amp_cause: assert property (p_amp_cause) else $error("amp on with input low");
  a_wd_lvl: assert property (p_wd_lvl) else $error("watchdog level not a thermometer");
endmodule : lds_port_chk
bind lds_port lds_port_chk u_chk (.*);
`default_nettype wire

// ---- test/lds_host.sv ----
`default_nettype none
module lds_host (
  input wire logic clk,
  input wire logic sdo_i,
  output var logic chip_select_n,
  output var logic sck,
  output var logic sdi,
  output var logic [23:0] rsp,
  output var logic rsp_stb
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    chip_select_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    rsp = 24'h0;
    rsp_stb = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  // ----------------------------------------
  // One frame, MSB first, 320 ns clock
  // ----------------------------------------
  task automatic frame(input logic [23:0] f, input int nb);
    step(1);
    sdi = f[23];
    chip_select_n = 1'b0;
    step(4);
    for (int i = 0; i < nb; i++) begin
      sck = 1'b1;
      rsp = {rsp[22:0], sdo_i};
      step(4);
      sck = 1'b0;
      f = f << 1;
      sdi = f[23];
      step(4);
    end
    chip_select_n = 1'b1;
    sdi = ~sdi;
    rsp_stb = 1'b1;
    step(1);
    rsp_stb = 1'b0;
    step(6);
  endtask : frame
endmodule : lds_host
`default_nettype wire

// ---- test/testbench.sv ----
`include "lds_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import lds_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dim_logic_in = 1'b0;
  logic [3:0] monitor_src = 4'h0;
  logic [15:0] fault_src = 16'h0;
  logic [15:0] state_src = 16'h0;
  logic chip_select_n, sck, sdi, sdo_o, sdo_oe, rsp_stb;
  logic [23:0] rsp;
  logic monitor_out, monitor_oe, ntc_foldback_en, internal_temp_mon, fallback_active;
  logic watchdog_timeout_select, dither_en, amp_connect, converter_on, dimming_switch;
  logic [2:0] watchdog_level;
  logic [4:0] deviation_pct, led_current_code, input_limit_code;
  logic [1:0] mod_rate_code;
  wire sdo_pin = sdo_oe ? sdo_o : 1'bz;
  int error_cnt = 0;
  int n_checks = 0;
  logic [47:0] q[$];
  logic [47:0] e;
  logic [15:0] sh[0:63];
  logic [15:0] v;
  // Identity values are arbitrary
  localparam logic [5:0] IA[5] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h3E};
  localparam logic [15:0] IV[5] = '{16'hA5A0, 16'h0001, 16'h1234, 16'h5678, 16'h9ABC};
  lds_port #(.WD_SHORT_CYC(20000), .WD_LONG_CYC(40000)) dut (.*);
  lds_host host (.clk(clk), .sdo_i(sdo_pin), .chip_select_n(chip_select_n), .sck(sck),
    .sdi(sdi), .rsp(rsp), .rsp_stb(rsp_stb));
  always #20 clk = ~clk;
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [23:0] g, input logic [23:0] x);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask : chk
  always @(posedge rsp_stb) begin
    e = q.pop_front();
    chk(rsp & e[47:24], e[23:0]);
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  function automatic logic [15:0] msk(input logic [5:0] a);
    return a == 6'h01 ? `LDS_CTRL1_MASK : a == 6'h02 ? `LDS_CTRL2_MASK :
      a == 6'h03 ? `LDS_CTRL3_MASK : 16'h0000;
  endfunction : msk
  task automatic xfer(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
      input logic [23:0] m, input logic [23:0] x, input int nb = 24);
    q.push_back({m, x});
    host.frame({op, a, d}, nb);
  endtask : xfer
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    xfer(LDS_OP_WRITE, a, d, 24'h00FFFF, {8'h00, sh[a]});
    sh[a] = d & msk(a);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    xfer(LDS_OP_READ, a, 16'($urandom), 24'h00FFFF, {8'h00, sh[a]});
  endtask : rd
  task automatic pulse(input logic [15:0] f);
    fault_src = f;
    step(2);
    fault_src = 16'h0;
    step(2);
  endtask : pulse
  task automatic meas(input logic lvl, input int na, input int nb);
    int ta;
    int tb;
    ta = 999;
    tb = 999;
    dim_logic_in = lvl;
    for (int n = 1; n < 300; n++) begin
      step(1);
      if (ta == 999 && (lvl ? amp_connect : !dimming_switch) === 1'b1) ta = n;
      if (tb == 999 && converter_on === lvl) tb = n;
    end
    chk(ta >= na && ta <= na + 6, 1'b1);
    chk(tb >= nb && tb <= nb + 6, 1'b1);
  endtask : meas
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h6306));
    foreach (sh[i]) sh[i] = 16'h0000;
    sh[1] = `LDS_CTRL1_RST;
    sh[2] = `LDS_CTRL2_RST;
    sh[3] = `LDS_CTRL3_RST;
    step(12);
    rst = 1'b0;
    step(4);
    for (int a = 1; a < 4; a++) rd(6'(a));
    rd(6'h10);
    wr(6'h00, 16'hFFFF);
    rd(6'h00);
    repeat (3) begin
      v = 16'($urandom);
      wr(6'h02, v);
      chk(led_current_code, v[9:5]);
      chk(input_limit_code, v[4:0]);
      chk(mod_rate_code, v[12:11]);
      chk({dither_en, deviation_pct}, {v[10], (v[15:13] == 3'h7 ? 5'h1E : 5'(v[15:13] * 5))});
    end
    rd(6'h02);
    for (int m = 0; m < 4; m++) begin
      wr(6'h01, {10'h000, 2'(m), 4'hE | 4'(m & 1)});
      monitor_src = 4'($urandom);
      step(6);
      chk({monitor_oe, monitor_out}, {1'b1, monitor_src[m]});
    end
    wr(6'h01, 16'hFFFF);
    rd(6'h01);
    wr(6'h01, 16'h0006);
    chk(monitor_oe, 1'b0);
    chk(watchdog_timeout_select, 1'b1);
    wr(6'h03, 16'h1800);
    chk({fallback_active, internal_temp_mon, ntc_foldback_en}, 3'b110);
    wr(6'h03, 16'h0232);
    chk({fallback_active, internal_temp_mon, ntc_foldback_en}, 3'b001);
    meas(1'b1, 166, 126);
    meas(1'b0, 84, 1);
    xfer(LDS_OP_WRITE, 6'h03, 16'h0FFF, 24'h0, 24'h0, 20);
    xfer(LDS_OP_READ, 6'h03, 16'h0, 24'h40FFFF, {8'h40, sh[3]});
    xfer(LDS_OP_READ, 6'h03, 16'h0, 24'h40FFFF, {8'h00, sh[3]});
    for (int i = 0; i < 5; i++) begin
      xfer(LDS_OP_INFO, IA[i], 16'($urandom), 24'h00FFFF, {8'h00, IV[i]});
    end
    pulse(16'h0001);
    xfer(LDS_OP_RDCLR, 6'h04, 16'($urandom), 24'h00FFFF, 24'h000001);
    rd(6'h04);
    pulse(16'h0020);
    xfer(LDS_OP_RDCLR, 6'h3F, 16'($urandom), 24'h00FFFF, {8'h00, 15'h0, sh[1][0]});
    rd(6'h04);
    summarize();
  end
  initial begin
    #3000000;
    error_cnt++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
